// ### pkg/rfirq_pkg.sv
// Package of constants and types for the reader interrupt status logic
package rfirq_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] STATUS_OFFSET   = 8'h0c;
    localparam logic [7:0] PROTOCTL_OFFSET = 8'h01;
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [7:0] MASK_RESET      = 8'h3e;

    // ==========================================================
    // Status bit positions
    localparam int BIT_TX     = 7;
    localparam int BIT_SRX    = 6;
    localparam int BIT_FIFO   = 5;
    localparam int BIT_CRC    = 4;
    localparam int BIT_PARITY = 3;
    localparam int BIT_FRAME  = 2;
    localparam int BIT_COL    = 1;
    localparam int BIT_NORESP = 0;

    // ==========================================================
    // FIFO level limits and collision thresholds
    localparam logic [3:0] FIFO_HIGH_LIMIT = 4'h8;
    localparam logic [3:0] FIFO_LOW_LIMIT  = 4'h4;
    localparam logic [3:0] COL_THRESH_LO   = 4'h6;
    localparam logic [3:0] COL_THRESH_HI   = 4'h7;

    // Protocol selection seen by the status logic
    typedef enum logic [1:0] {
        PROT_14443A,
        PROT_15693_SINGLE,
        PROT_15693_DOUBLE,
        PROT_OTHER
    } rfirq_prot_e;

    // Events from transmitter, decoder and FIFO
    typedef struct packed {
        logic       txStart;
        logic       txEnd;
        logic       rxSof;
        logic       rxEnd;
        logic       crcBad;
        logic       parityBad;
        logic       frameBad;
        logic       noRespTimeout;
        logic [3:0] colCount;
        logic       colCountValid;
        logic [3:0] fifoLevel;
    } rfirq_evt_s;

    // Host register access port
    typedef struct packed {
        logic       readDone;
        logic       writeStrobe;
        logic [7:0] addr;
    } rfirq_host_s;

endpackage : rfirq_pkg

// ### verilog/rfirq_status.sv
// Interrupt status register and interrupt line of the reader front end
`timescale 1ns/100ps

// Behaviour
// [RQ1] Status clears on reset, on chip enable low and on any protocol control write.
// [RQ2] Status clears once a host read of it has completed, keeping only flags set again in that same cycle.
// [RQ3] That read also drops the interrupt line, which is how the host acknowledges.
// [RQ4] During transmit only the FIFO and transmit flags may change.
// [RQ5] During receive only the receive-start flag, or the transmit flag on a transmit start, may change, without raising the line.
// [RQ6] The line rises when a transmit or receive phase ends, or in idle when an enabled result flag is set.
// [RQ7] The transmit flag sets at transmit start; its request comes at transmit end.
// [RQ8] The receive-start flag sets at start of frame; its request comes at receive end.
// [RQ9] The FIFO flag sets above eight entries outside transmit and receive or below four in transmit.
// [RQ10] The CRC flag sets on a bad CRC only while receive CRC checking is on.
// [RQ11] The parity flag sets on a parity failure under 14443 A.
// [RQ12] The framing flag sets on a byte framing error or bad end of frame.
// [RQ13] The collision flag sets above a six or seven event threshold in one bit period.
// [RQ14] The no-response flag sets on wait timeout in 15693 only.
// [RQ15] A mask register gates the six result sources (bits 5 to 0) and resets to enable all of them but no-response.
// [RQ16] Flags set after phase end are held till read and keep an enabled line up.
module rfirq_status
    import rfirq_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        chipEnable,
    input  wire rfirq_host_s host,
    input  wire logic [7:0]  maskWrData,
    input  wire logic        maskWrite,
    input  wire rfirq_evt_s  evt,
    input  wire rfirq_prot_e protocol,
    input  wire logic        noRxCrc,
    input  wire logic        colThreshSel,
    output logic [7:0]       statusRd_q,
    output logic [7:0]       mask_q,
    output logic             irq_q,
    output logic             decoderEnable_q
);

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_TX,
        PH_RX
    } rfirq_phase_e;

    rfirq_phase_e phase_q;
    logic [7:0]   status_q;
    logic [7:0]   setBits;
    logic [3:0]   colThresh;
    logic         clearAll;
    logic         phaseEnd;
    logic         pending_q;

    // Status clear sources
    assign clearAll = reset || !chipEnable
                   || (host.writeStrobe && host.addr == PROTOCTL_OFFSET)   // see [RQ1]
                   || (host.readDone && host.addr == STATUS_OFFSET);       // see [RQ2]

    assign colThresh = colThreshSel ? COL_THRESH_HI : COL_THRESH_LO;
    assign phaseEnd  = (phase_q == PH_TX && evt.txEnd)
                    || (phase_q == PH_RX && evt.rxEnd);

    // ==========================================================
    // Event qualification per phase
    always_comb begin
        setBits = 8'h00;
        unique case (phase_q)
            PH_TX: begin
                setBits[BIT_FIFO] = evt.fifoLevel < FIFO_LOW_LIMIT;       // see [RQ4] [RQ9]
            end
            PH_RX: begin
                setBits[BIT_SRX] = evt.rxSof;                              // see [RQ5] [RQ8]
            end
            PH_IDLE: begin
                // Receive result flags land once the phase is over
                setBits[BIT_CRC]    = evt.crcBad && !noRxCrc;              // see [RQ10]
                setBits[BIT_PARITY] = evt.parityBad
                                   && protocol == PROT_14443A;             // see [RQ11]
                setBits[BIT_FRAME]  = evt.frameBad;                        // see [RQ12]
                setBits[BIT_COL]    = evt.colCountValid
                                   && evt.colCount > colThresh
                                   && (protocol == PROT_14443A
                                    || protocol == PROT_15693_SINGLE);    // see [RQ13]
                setBits[BIT_NORESP] = evt.noRespTimeout
                                   && (protocol == PROT_15693_SINGLE
                                    || protocol == PROT_15693_DOUBLE);    // see [RQ14]
                setBits[BIT_FIFO]   = evt.fifoLevel > FIFO_HIGH_LIMIT;   // see [RQ9]
                // Start of frame opens the receive phase and marks it
                setBits[BIT_SRX]    = evt.rxSof && !evt.txStart;           // see [RQ8]
            end
            default: begin
                setBits = 8'h00;
            end
        endcase
        if (evt.txStart) begin
            setBits[BIT_TX] = 1'b1;                                        // see [RQ7]
        end
    end

    // ==========================================================
    // Phase tracking
    always_ff @(posedge clock) begin
        if (reset || !chipEnable) begin
            phase_q <= PH_IDLE;
        end else if (evt.txStart) begin
            phase_q <= PH_TX;
        end else if (phaseEnd) begin
            phase_q <= PH_IDLE;
        end else if (phase_q == PH_IDLE && evt.rxSof) begin
            phase_q <= PH_RX;
        end
    end

    // Decoder off while transmitting
    always_ff @(posedge clock) begin
        if (reset || !chipEnable) begin
            decoderEnable_q <= 1'b1;
        end else begin
            decoderEnable_q <= !(evt.txStart || (phase_q == PH_TX && !evt.txEnd)); // see [RQ4]
        end
    end

    // ==========================================================
    // Status register; a new event wins over a read clear
    always_ff @(posedge clock) begin
        if (reset || !chipEnable) begin
            status_q <= STATUS_RESET;                                      // see [RQ1]
        end else if (clearAll) begin
            status_q <= setBits;                                           // see [RQ2]
        end else begin
            status_q <= status_q | setBits;                                // see [RQ16]
        end
    end

    // Read data copy of the status
    always_ff @(posedge clock) begin
        if (reset) begin
            statusRd_q <= STATUS_RESET;
        end else begin
            statusRd_q <= status_q;
        end
    end

    // Interrupt enable mask
    always_ff @(posedge clock) begin
        if (reset || !chipEnable) begin
            mask_q <= MASK_RESET;                                          // see [RQ15]
        end else if (maskWrite) begin
            mask_q <= maskWrData;
        end
    end

    // ==========================================================
    // Pending request, armed at phase end, dropped by the read
    always_ff @(posedge clock) begin
        if (reset || !chipEnable) begin
            pending_q <= 1'b0;
        end else if (phaseEnd) begin
            pending_q <= 1'b1;                                             // see [RQ6]
        end else if (clearAll) begin
            pending_q <= 1'b0;                                             // see [RQ3]
        end
    end

    // Interrupt line
    always_ff @(posedge clock) begin
        if (reset || !chipEnable) begin
            irq_q <= 1'b0;
        end else if (phaseEnd) begin
            irq_q <= 1'b1;                                                 // see [RQ7] [RQ8]
        end else if (clearAll) begin
            irq_q <= |(setBits[5:0] & mask_q[5:0]) && phase_q == PH_IDLE;  // see [RQ3]
        end else if (phase_q == PH_IDLE) begin
            irq_q <= pending_q
                  || |(status_q[5:0] & mask_q[5:0])
                  || |(setBits[5:0] & mask_q[5:0]);                        // see [RQ16]
        end
    end

endmodule : rfirq_status

// ### tb/rfirq_status_properties.sv
// Port checks of the interrupt status logic
`timescale 1ns/100ps
module rfirq_status_properties
    import rfirq_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        chipEnable,
    input wire rfirq_host_s host,
    input wire logic [7:0]  maskWrData,
    input wire logic        maskWrite,
    input wire rfirq_evt_s  evt,
    input wire logic [7:0]  statusRd_q,
    input wire logic [7:0]  mask_q,
    input wire logic        irq_q,
    input wire logic        decoderEnable_q
);
    // ==========
    // Helper terms
    logic rdStat, ctlWr, calm, keep, quiet;
    assign rdStat = host.readDone && host.addr == STATUS_OFFSET;
    assign ctlWr = host.writeStrobe && host.addr == PROTOCTL_OFFSET;
    // No ending or result event, FIFO level neither high nor low
    assign calm = !evt.txEnd && !evt.rxEnd && evt[12:4] == 9'h000
        && evt.fifoLevel inside {[4'h4:4'h8]};
    assign keep = !rdStat && !ctlWr && chipEnable;
    assign quiet = calm && chipEnable && !evt.txStart && !evt.rxSof;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // ==========
    // Assertions
    a_read_clears: assert property (
        rdStat && quiet ##1 quiet |=> !irq_q && statusRd_q == 8'h00) else $error("read no clear");
    a_ctl_clears: assert property (
        ctlWr && quiet ##1 quiet |=> statusRd_q == 8'h00) else $error("ctl write no clear");
    a_enable_clears: assert property (
        !chipEnable ##1 !chipEnable |=> statusRd_q == 8'h00 && !irq_q && mask_q == MASK_RESET)
        else $error("enable low no clear");
    a_tx_start: assert property (
        evt.txStart && calm && keep ##1 calm && keep |=> !decoderEnable_q && statusRd_q[BIT_TX])
        else $error("tx start wrong");
    a_tx_end_line: assert property (
        evt.txEnd && !decoderEnable_q && chipEnable |=> irq_q) else $error("no line at tx end");
    a_sof_quiet: assert property (
        evt.rxSof && decoderEnable_q && !irq_q && calm && keep && !maskWrite |=> !irq_q)
        else $error("line at sof");
    a_line_holds: assert property (
        irq_q && keep && !maskWrite |=> irq_q) else $error("line dropped");
    a_mask_write: assert property (
        maskWrite && chipEnable |=> mask_q == $past(maskWrData)) else $error("mask not written");
    c_tx_end: cover property (evt.txEnd && !decoderEnable_q);
    c_read_line: cover property (rdStat && irq_q);
    c_enable_low: cover property (!chipEnable);
endmodule : rfirq_status_properties

// ### tb/rfirq_host_model.sv
// Host controller model making one-cycle register accesses
`timescale 1ns/100ps
module rfirq_host_model
    import rfirq_pkg::*;
(
    input wire logic       clock,
    input wire logic [7:0] statusRd_q,
    output rfirq_host_s    host
);
    initial host = '0;
    // Strobe one access, take read data after the strobe edge
    task automatic access(input logic wr, input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        host <= '{readDone: !wr, writeStrobe: wr, addr: a};
        @(posedge clock);
        host <= '0;
        #1 d = statusRd_q;
    endtask : access
endmodule : rfirq_host_model

// ### tb/tb_rfid_irq_status_logic.sv
// Self-checking bench of the reader interrupt status logic
`timescale 1ns/100ps
module tb_rfid_irq_status_logic
    import rfirq_pkg::*;
;
    logic        clock = 1'b0, reset = 1'b1, chipEnable = 1'b1, maskWrite = 1'b0;
    logic        noRxCrc = 1'b0, colThreshSel = 1'b0, irq_q, decoderEnable_q;
    logic [7:0]  maskWrData = 8'h00, statusRd_q, mask_q, d;
    rfirq_evt_s  evt = 17'h00006;
    rfirq_prot_e protocol = PROT_14443A;
    rfirq_host_s host;
    int          errors = 0, total_checks = 0, cycles = 0;
    initial forever #25 clock = ~clock;
    rfirq_status i_dut (.clock(clock), .reset(reset), .chipEnable(chipEnable), .host(host),
        .maskWrData(maskWrData), .maskWrite(maskWrite), .evt(evt), .protocol(protocol),
        .noRxCrc(noRxCrc), .colThreshSel(colThreshSel), .statusRd_q(statusRd_q),
        .mask_q(mask_q), .irq_q(irq_q), .decoderEnable_q(decoderEnable_q));
    rfirq_host_model i_host (.clock(clock), .statusRd_q(statusRd_q), .host(host));
    // Compare and count
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One-cycle event pulse at a FIFO level, then idle
    task automatic fire(input logic [7:0] p, input logic [3:0] c, input logic [3:0] f);
        @(posedge clock);
        evt <= {p, c, c != 4'h0, f};
        @(posedge clock);
        evt <= {13'h0000, 4'h6};
    endtask : fire
    task automatic rdChk(input logic [7:0] e);
        i_host.access(1'b0, STATUS_OFFSET, d);
        chk("status", e, d);
    endtask : rdChk
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            errors++;
            conclude();
        end
    end
    // Test sequence
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        #1 chk("mask", MASK_RESET, mask_q);
        rdChk(STATUS_RESET);
        $display("reset test done");
        fire(8'h80, 4'h0, 4'h6);
        #1 chk("decoder", 8'h00, decoderEnable_q);
        chk("line", 8'h00, irq_q);
        fire(8'h0e, 4'h8, 4'h2);
        fire(8'h40, 4'h0, 4'h6);
        #1 chk("line", 8'h01, irq_q);
        chk("decoder", 8'h01, decoderEnable_q);
        rdChk(8'ha0);
        chk("line", 8'h00, irq_q);
        $display("transmit test done");
        fire(8'h20, 4'h0, 4'h6);
        fire(8'h0c, 4'h8, 4'h9);
        #1 chk("line", 8'h00, irq_q);
        fire(8'h10, 4'h0, 4'h6);
        #1 chk("line", 8'h01, irq_q);
        rdChk(8'h40);
        fire(8'h0e, 4'h7, 4'h9);
        rdChk(8'h3e);
        $display("receive test done");
        @(posedge clock);
        protocol <= PROT_15693_SINGLE;
        noRxCrc <= 1'b1;
        colThreshSel <= 1'b1;
        fire(8'h0d, 4'h7, 4'h6);
        #1 chk("line", 8'h00, irq_q);
        i_host.access(1'b0, 8'h0d, d);
        rdChk(8'h01);
        @(posedge clock);
        maskWrData <= 8'h01;
        maskWrite <= 1'b1;
        @(posedge clock);
        maskWrite <= 1'b0;
        fire(8'h01, 4'h0, 4'h6);
        #1 chk("line", 8'h01, irq_q);
        i_host.access(1'b1, PROTOCTL_OFFSET, d);
        rdChk(8'h00);
        fire(8'h01, 4'h0, 4'h6);
        @(posedge clock);
        chipEnable <= 1'b0;
        repeat (2) @(posedge clock);
        chipEnable <= 1'b1;
        #1 chk("mask", MASK_RESET, mask_q);
        chk("line", 8'h00, irq_q);
        rdChk(8'h00);
        $display("clear test done");
        conclude();
    end
endmodule : tb_rfid_irq_status_logic
bind rfirq_status rfirq_status_properties i_chk (.clock(clock), .reset(reset),
    .chipEnable(chipEnable), .host(host), .maskWrData(maskWrData), .maskWrite(maskWrite),
    .evt(evt), .statusRd_q(statusRd_q), .mask_q(mask_q), .irq_q(irq_q),
    .decoderEnable_q(decoderEnable_q));
